// *** logic/hppd_top.sv ***
/*
 * Hub port power and descriptor logic: per-port power switching with
 * overload cut-off, over-current status and change bits, connection
 * indicators, status change bitmap, oscillator stop in suspend and a
 * registered descriptor byte read port.
 * Assumes the request decoder outside decodes host requests into the
 * one-cycle pulses seen here, and the sense comparators are synchronous.
 */
`timescale 1ns/100ps
module hppd_top
   import hppd_pkg::*;
#(
   parameter int unsigned N_PORTS = NUM_PORTS, // Downstream port count.
   parameter int unsigned FAULT_CNT = FAULT_CYCLES, // Fault qualification cycles.
   parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value.
   parameter logic [15:0] PRODUCT_ID = 16'h5678, // Arbitrary value.
   parameter logic [15:0] DEV_RELEASE = 16'h0100 // Arbitrary value.
)
(
   input wire logic i_clk_sys, // System clock, 25 MHz.
   input wire logic i_srst, // Synchronous reset, active high.
   input wire logic i_init_done, // Hub initialization complete.
   input wire logic i_suspend, // Hub is in the suspended state.
   input wire logic [N_PORTS-1:0] i_port_power_on_request, // Set port power pulse.
   input wire logic [N_PORTS-1:0] i_port_power_off_request, // Clear port power pulse.
   input wire logic [N_PORTS-1:0] i_port_enable, // Port enabled by the hub.
   input wire logic [N_PORTS-1:0] i_port_supply_sense, // High while supply above reference.
   input wire logic [N_PORTS-1:0] i_clr_oc_change, // Clear over-current change pulse.
   input wire logic i_hub_change, // Hub status change level.
   input wire logic [1:0] i_desc_sel, // Descriptor selector.
   input wire logic [4:0] i_desc_idx, // Descriptor byte index.
   output logic [N_PORTS-1:0] o_port_power_ctl_n_oe, // Low-drive enable of power pin.
   output logic [N_PORTS-1:0] o_port_power_ctl_n_out, // Driven level, always zero.
   output logic [N_PORTS-1:0] o_port_stat, // Connection indicator, high active.
   output logic [N_PORTS-1:0] o_port_over_current, // Over-current status bits.
   output logic [N_PORTS-1:0] o_c_port_over_current, // Over-current change bits.
   output logic [7:0] o_status_change, // Status change bitmap.
   output logic o_osc_run, // Oscillator enable.
   output logic [7:0] o_desc_byte, // Registered descriptor byte.
   output logic [7:0] o_desc_len // Registered descriptor length.
);
   import hppd_pkg::*;

   // Refuse port counts the bitmap and the design cannot carry.
   initial
   begin
      if (N_PORTS < 1 || N_PORTS > 7)
      begin
         $error("hppd_top: N_PORTS must lie between 1 and 7.");
      end
      if (FAULT_CNT < 1)
      begin
         $error("hppd_top: FAULT_CNT must be at least one.");
      end
   end

   // Hub start-up phases; power stays off until the hub is up.
   typedef enum logic [1:0]
   {
      ST_INIT = 2'b01,
      ST_RUN = 2'b10
   } hppd_state_t;

   hppd_state_t state_r; // Current phase.
   hppd_state_t state_nxt; // Next phase.
   logic running_w; // Hub initialized and accepting power requests.

   // Phase selection.
   always_comb
   begin
      case (state_r)
         ST_INIT: state_nxt = i_init_done ? ST_RUN : ST_INIT;
         ST_RUN: state_nxt = ST_RUN;
         default: state_nxt = ST_INIT;
      endcase
   end

   // Phase register.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         state_r <= ST_INIT;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign running_w = (state_r == ST_RUN);

   logic [N_PORTS-1:0] power_r; // Port power switched on.
   logic [N_PORTS-1:0] power_nxt; // Next power state.
   logic [N_PORTS-1:0] oc_r; // Over-current status.
   logic [N_PORTS-1:0] oc_nxt; // Next over-current status.
   logic [N_PORTS-1:0] coc_r; // Over-current change.
   logic [N_PORTS-1:0] coc_nxt; // Next over-current change.
   logic [N_PORTS-1:0] stat_r; // Indicator state.
   logic [N_PORTS-1:0] stat_nxt; // Next indicator state.
   logic [N_PORTS-1:0] fault_w; // Qualified fault pulses.

   // Per-port fault filter and next-state logic.
   genvar gp;
   generate
      for (gp = 0; gp < N_PORTS; gp++)
      begin : g_port
         hppd_fault_filter #(
            .CYCLES(FAULT_CNT)
         ) u_filt (
            .i_clk_sys(i_clk_sys),
            .i_srst(i_srst),
            .i_arm(power_r[gp]),
            .i_low(!i_port_supply_sense[gp]),
            .o_fault(fault_w[gp])
         );

         // A fault wins over a same-cycle power-on request, so a short stays off.
         assign power_nxt[gp] = !running_w ? 1'b0 :
                                fault_w[gp] ? 1'b0 :
                                i_port_power_on_request[gp] ? 1'b1 :
                                i_port_power_off_request[gp] ? 1'b0 : power_r[gp];

         // Status follows the fault and clears when power is requested again.
         assign oc_nxt[gp] = fault_w[gp] ? 1'b1 :
                             (i_port_power_on_request[gp] ? 1'b0 : oc_r[gp]);

         // Change bit: the set wins over a clear arriving in the same cycle.
         assign coc_nxt[gp] = fault_w[gp] ? 1'b1 :
                              (i_clr_oc_change[gp] ? 1'b0 : coc_r[gp]);

         // Indicator shows an enabled, powered port.
         assign stat_nxt[gp] = power_nxt[gp] && i_port_enable[gp];
      end
   endgenerate

   // Port state registers; reset leaves every port unpowered.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         power_r <= '0;
         oc_r <= '0;
         coc_r <= '0;
         stat_r <= '0;
      end
      else
      begin
         power_r <= power_nxt;
         oc_r <= oc_nxt;
         coc_r <= coc_nxt;
         stat_r <= stat_nxt;
      end
   end

   // Open drain: enable drives the pin low, otherwise the pull-up holds it high.
   assign o_port_power_ctl_n_oe = power_r;
   assign o_port_power_ctl_n_out = '0;
   assign o_port_stat = stat_r;
   assign o_port_over_current = oc_r;
   assign o_c_port_over_current = coc_r;

   logic [7:0] chg_r; // Status change bitmap register.
   logic [7:0] chg_nxt; // Next bitmap.

   // Bit 0 carries the hub change, ports follow, spare bits stay zero.
   assign chg_nxt = 8'({coc_r, i_hub_change});

   // Bitmap register.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         chg_r <= '0;
      end
      else
      begin
         chg_r <= chg_nxt;
      end
   end

   assign o_status_change = chg_r;

   logic osc_r; // Oscillator enable register.

   // The oscillator is held off while suspended to save power; the system
   // clock here is assumed to be the PLL output from the 6 MHz reference.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         osc_r <= 1'b1;
      end
      else
      begin
         osc_r <= !i_suspend;
      end
   end

   assign o_osc_run = osc_r;

   logic [7:0] rom_byte_w; // Descriptor byte from the table.
   logic [7:0] rom_len_w; // Descriptor length from the table.

   hppd_desc_rom #(
      .VENDOR_ID(VENDOR_ID),
      .PRODUCT_ID(PRODUCT_ID),
      .DEV_RELEASE(DEV_RELEASE)
   ) u_rom (
      .i_sel(i_desc_sel),
      .i_idx(i_desc_idx),
      .o_byte(rom_byte_w),
      .o_len(rom_len_w)
   );

   logic [7:0] desc_byte_r; // Registered descriptor byte.
   logic [7:0] desc_len_r; // Registered descriptor length.

   // Descriptor read port, one cycle of latency.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         desc_byte_r <= '0;
         desc_len_r <= '0;
      end
      else
      begin
         desc_byte_r <= rom_byte_w;
         desc_len_r <= rom_len_w;
      end
   end

   assign o_desc_byte = desc_byte_r;
   assign o_desc_len = desc_len_r;

   // Power may only stand once the hub has left initialization.
   chk_power_needs_run: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      o_port_power_ctl_n_oe != '0 |-> running_w) else $error("Power while not running.");

   // Power on port 0 never appears without a request just before it.
   chk_power_after_req: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      $rose(o_port_power_ctl_n_oe[0]) |-> $past(i_port_power_on_request[0]))
      else $error("Power rose without request.");

   // A request taken while running powers the port at the next edge.
   chk_req_powers: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      running_w && i_port_power_on_request[0] && !fault_w[0] |=> o_port_power_ctl_n_oe[0])
      else $error("Request did not power the port.");

   // A qualified fault drops the power and raises the status bit together.
   chk_fault_cuts_power: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      fault_w[0] |=> !o_port_power_ctl_n_oe[0] && o_port_over_current[0])
      else $error("Fault did not cut power.");

   // The change bit follows the fault, and the bitmap one cycle after it.
   chk_fault_sets_chg: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      fault_w[0] |=> o_c_port_over_current[0] ##1 o_status_change[1])
      else $error("Fault change bit missing.");

   // Over-current status stands until the host powers the port again.
   chk_oc_holds: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      o_port_over_current[0] && !i_port_power_on_request[0] |=> o_port_over_current[0])
      else $error("Over-current status dropped early.");

   // The indicator never shows on an unpowered port.
   chk_stat_when_on: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      o_port_stat[0] |-> o_port_power_ctl_n_oe[0]) else $error("Indicator while off.");

   // A powered port that was enabled shows its indicator.
   chk_stat_follows_en: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      o_port_power_ctl_n_oe[0] && $past(i_port_enable[0]) |-> o_port_stat[0])
      else $error("Indicator missing on enabled port.");

   // Bits above the last port are spare; the shift keeps this legal for any port count.
   chk_bitmap_spare: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      (o_status_change >> (N_PORTS + 1)) == '0) else $error("Spare bitmap bits set.");

   // The oscillator stops the cycle after suspend is seen.
   chk_osc_suspend: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_suspend |=> !o_osc_run) else $error("Oscillator ran in suspend.");

   // It starts again the cycle after suspend ends.
   chk_osc_resume: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      !i_suspend |=> o_osc_run) else $error("Oscillator held off while awake.");

   // Selecting the device descriptor reads its length one cycle later.
   chk_desc_len: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      i_desc_sel == SEL_DEVICE |=> o_desc_len == DEV_LEN) else $error("Bad device length.");

   // Independent tally of each dip, kept apart from the filter so that the
   // dip checks do not merely restate the filter's own arithmetic.
   localparam int unsigned LRW = $clog2(FAULT_CNT + 2);

   genvar gc;
   generate
      for (gc = 0; gc < N_PORTS; gc++)
      begin : g_chk
         logic [LRW-1:0] low_run_r; // Powered cycles with the supply below reference.

         // The tally saturates at the limit and restarts when the supply recovers.
         always_ff @(posedge i_clk_sys)
         begin
            if (i_srst || !power_r[gc] || i_port_supply_sense[gc])
            begin
               low_run_r <= '0;
            end
            else if (low_run_r != LRW'(FAULT_CNT))
            begin
               low_run_r <= low_run_r + 1'b1;
            end
         end

         // A dip shorter than the limit never trips the port.
         chk_short_dip_ok: assert property (@(posedge i_clk_sys) disable iff (i_srst)
            fault_w[gc] |-> low_run_r == LRW'(FAULT_CNT) && !i_port_supply_sense[gc])
            else $error("Fault on a short dip.");

         // A dip that outlasts the limit always trips the port.
         chk_long_dip_trips: assert property (@(posedge i_clk_sys) disable iff (i_srst)
            power_r[gc] && !i_port_supply_sense[gc] && low_run_r == LRW'(FAULT_CNT) |->
            fault_w[gc]) else $error("Long dip did not trip.");
      end
   endgenerate
endmodule : hppd_top

// *** logic/hppd_pkg.sv ***
/*
 * Package for the hub port power and descriptor block: clock rate, fault
 * qualification time, port count, descriptor byte values and indices.
 * Assumes a single 25 MHz system clock; nothing else is shared.
 */
package hppd_pkg;
   // System clock rate in kHz.
   localparam int unsigned CLK_KHZ = 25000;
   // Least time a sense dip must last to count as a fault, in microseconds.
   localparam int unsigned FAULT_TIME_US = 1000;
   // Cycles for the fault time, rounded up.
   localparam int unsigned FAULT_CYCLES = (FAULT_TIME_US * CLK_KHZ + 999) / 1000;
   // Number of downstream ports.
   localparam int unsigned NUM_PORTS = 4;
   // Reference clock rate expected for the oscillator, in kHz.
   localparam int unsigned REF_CLK_KHZ = 6000;
   // Descriptor type selector codes on the read port.
   localparam logic [1:0] SEL_DEVICE = 2'h0;
   localparam logic [1:0] SEL_CONFIG = 2'h1;
   localparam logic [1:0] SEL_IFACE = 2'h2;
   // Descriptor lengths in bytes.
   localparam logic [7:0] DEV_LEN = 8'h12;
   localparam logic [7:0] CFG_LEN = 8'h09;
   localparam logic [7:0] IFC_LEN = 8'h09;
   // Descriptor type bytes.
   localparam logic [7:0] DEV_TYPE = 8'h00;
   localparam logic [7:0] CFG_TYPE = 8'h02;
   localparam logic [7:0] IFC_TYPE = 8'h04;
   // Class and field values.
   localparam logic [15:0] USB_REL = 16'h0100;
   localparam logic [7:0] HUB_CLASS = 8'h09;
   localparam logic [7:0] EP0_MAXPKT = 8'h08;
   localparam logic [7:0] NUM_CONFIGS = 8'h01;
   localparam logic [15:0] CFG_TOTAL = 16'h0022;
   localparam logic [7:0] NUM_IFACES = 8'h01;
   localparam logic [7:0] CFG_VALUE = 8'h01;
   localparam logic [7:0] CFG_ATTR = 8'hA0;
   localparam logic [7:0] CFG_MAXPWR = 8'hFA;
   localparam logic [7:0] IFC_NUM_EP = 8'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Status change bitmap: hub bit position.
   localparam int unsigned CHG_HUB_BIT = 0;
endpackage : hppd_pkg

// *** logic/hppd_fault_filter.sv ***
/*
 * One port's supply fault qualifier: counts cycles while the sense input
 * sits below the reference and holds o_fault high for as long as the dip
 * continues, once the dip has lasted longer than the qualification time.
 * Assumes the sense comparator output is synchronous to i_clk_sys.
 */
`timescale 1ns/100ps
module hppd_fault_filter
   import hppd_pkg::*;
#(
   parameter int unsigned CYCLES = FAULT_CYCLES // Qualification length in cycles.
)
(
   input wire logic i_clk_sys, // System clock.
   input wire logic i_srst, // Synchronous reset, active high.
   input wire logic i_arm, // Count only while the port is powered.
   input wire logic i_low, // Supply sense below the reference.
   output logic o_fault // High while a qualified fault lasts and the port stays armed.
);
   localparam int unsigned CW = $clog2(CYCLES + 2);

   initial
   begin
      if (CYCLES < 1)
      begin
         $error("hppd_fault_filter: CYCLES must be at least one.");
      end
   end

   logic [CW-1:0] cnt_r; // Cycles spent below the reference.
   logic [CW-1:0] cnt_nxt; // Next count.
   logic done_w; // Dip has now lasted as long as the limit.

   // The count restarts on any return above the threshold, so short dips vanish.
   assign done_w = (cnt_r == CW'(CYCLES));
   assign cnt_nxt = (!i_arm || !i_low) ? '0 : (done_w ? cnt_r : cnt_r + 1'b1);

   // Counter register.
   always_ff @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         cnt_r <= '0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   // Fault fires while the count stands at the limit and the dip continues.
   assign o_fault = done_w && i_arm && i_low;

   chk_fault_needs_dip: assert property (@(posedge i_clk_sys) disable iff (i_srst)
      o_fault |-> $past(i_low) && $past(i_arm)) else $error("Fault without a dip.");
endmodule : hppd_fault_filter

// *** logic/hppd_desc_rom.sv ***
/*
 * Fixed descriptor contents for the device, configuration and interface
 * descriptors, read one byte at a time by selector and byte index.
 * Assumes the request decoder outside picks the selector and index.
 */
`timescale 1ns/100ps
module hppd_desc_rom
   import hppd_pkg::*;
#(
   parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value.
   parameter logic [15:0] PRODUCT_ID = 16'h5678, // Arbitrary value.
   parameter logic [15:0] DEV_RELEASE = 16'h0100 // Arbitrary value.
)
(
   input wire logic [1:0] i_sel, // Descriptor selector.
   input wire logic [4:0] i_idx, // Byte index within the descriptor.
   output logic [7:0] o_byte, // Byte at that index.
   output logic [7:0] o_len // Length of the chosen descriptor.
);
   import hppd_pkg::*;

   logic [7:0] dev_w [0:17]; // Device descriptor bytes.
   logic [7:0] cfg_w [0:8]; // Configuration descriptor bytes.
   logic [7:0] ifc_w [0:8]; // Interface descriptor bytes.

   // Device descriptor; 16-bit fields go low byte first.
   assign dev_w[0] = DEV_LEN;
   assign dev_w[1] = DEV_TYPE;
   assign dev_w[2] = USB_REL[7:0];
   assign dev_w[3] = USB_REL[15:8];
   assign dev_w[4] = HUB_CLASS;
   assign dev_w[5] = ZERO_BYTE;
   assign dev_w[6] = ZERO_BYTE;
   assign dev_w[7] = EP0_MAXPKT;
   assign dev_w[8] = VENDOR_ID[7:0];
   assign dev_w[9] = VENDOR_ID[15:8];
   assign dev_w[10] = PRODUCT_ID[7:0];
   assign dev_w[11] = PRODUCT_ID[15:8];
   assign dev_w[12] = DEV_RELEASE[7:0];
   assign dev_w[13] = DEV_RELEASE[15:8];
   assign dev_w[14] = ZERO_BYTE;
   assign dev_w[15] = ZERO_BYTE;
   assign dev_w[16] = ZERO_BYTE;
   assign dev_w[17] = NUM_CONFIGS;

   // Configuration descriptor.
   assign cfg_w[0] = CFG_LEN;
   assign cfg_w[1] = CFG_TYPE;
   assign cfg_w[2] = CFG_TOTAL[7:0];
   assign cfg_w[3] = CFG_TOTAL[15:8];
   assign cfg_w[4] = NUM_IFACES;
   assign cfg_w[5] = CFG_VALUE;
   assign cfg_w[6] = ZERO_BYTE;
   assign cfg_w[7] = CFG_ATTR;
   assign cfg_w[8] = CFG_MAXPWR;

   // Interface descriptor.
   assign ifc_w[0] = IFC_LEN;
   assign ifc_w[1] = IFC_TYPE;
   assign ifc_w[2] = ZERO_BYTE;
   assign ifc_w[3] = ZERO_BYTE;
   assign ifc_w[4] = IFC_NUM_EP;
   assign ifc_w[5] = HUB_CLASS;
   assign ifc_w[6] = ZERO_BYTE;
   assign ifc_w[7] = ZERO_BYTE;
   assign ifc_w[8] = ZERO_BYTE;

   logic in_dev_w; // Index inside the device descriptor.
   logic in_nine_w; // Index inside a nine-byte descriptor.
   assign in_dev_w = (8'(i_idx) < DEV_LEN);
   assign in_nine_w = (8'(i_idx) < CFG_LEN);

   // Out-of-range indices and unknown selectors read as zero.
   assign o_byte = (i_sel == SEL_DEVICE && in_dev_w) ? dev_w[i_idx] :
                   (i_sel == SEL_CONFIG && in_nine_w) ? cfg_w[i_idx[3:0]] :
                   (i_sel == SEL_IFACE && in_nine_w) ? ifc_w[i_idx[3:0]] : ZERO_BYTE;
   assign o_len = (i_sel == SEL_DEVICE) ? DEV_LEN :
                  (i_sel == SEL_CONFIG) ? CFG_LEN :
                  (i_sel == SEL_IFACE) ? IFC_LEN : ZERO_BYTE;
endmodule : hppd_desc_rom

// *** dv/hppd_port_model.sv ***
/*
 * Model of the far side of the four port power pins: the pull-up resistors,
 * the external power switches and the supply sense comparators.
 * Assumes the hub only ever pulls a power pin low and releases it otherwise.
 */
`timescale 1ns/100ps
module hppd_port_model
(
   input wire logic [3:0] i_oe, // Low-drive enable from the hub.
   input wire logic [3:0] i_out, // Level the hub drives while enabled.
   input wire logic [3:0] i_overload, // Overload commanded by the bench.
   output logic [3:0] o_pin_n, // Resolved power pin level.
   output logic [3:0] o_sense // High while port supply is above reference.
);
   // The pull-up holds a released pin high, so an idle port stays unpowered.
   assign o_pin_n = (i_oe & i_out) | ~i_oe;
   // The switch feeds the port only while its pin is low; an overload drags
   // the supply under the reference, as a real short would.
   assign o_sense = ~o_pin_n & ~i_overload;
endmodule : hppd_port_model

// *** dv/tb_top.sv ***
/*
 * Self-checking bench for the hub port power and descriptor block: power
 * switching, overload cut-off, change bitmap, suspend and descriptor reads.
 * Assumes the port model stands in for the switches and sense comparators.
 */
`timescale 1ns/100ps
module tb_top;
   import hppd_pkg::*;
   localparam int unsigned FCNT = 20; // Shortened fault time keeps the run brief.
   localparam logic [15:0] VID = 16'hA5C3; // Arbitrary value.
   localparam logic [15:0] PID = 16'h6B2E; // Arbitrary value.
   localparam logic [15:0] REL = 16'h0201; // Arbitrary value.
   localparam logic [7:0] DEV [18] = '{8'h12, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00,
      8'h08, VID[7:0], VID[15:8], PID[7:0], PID[15:8], REL[7:0], REL[15:8], 8'h00, 8'h00,
      8'h00, 8'h01};
   localparam logic [7:0] CFG [9] = '{8'h09, 8'h02, 8'h22, 8'h00, 8'h01, 8'h01, 8'h00,
      8'hA0, 8'hFA};
   localparam logic [7:0] IFC [9] = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00,
      8'h00, 8'h00};
   logic clk = 1'b0; // System clock.
   logic srst = 1'b1; // Synchronous reset.
   logic init_done = 1'b0; // Initialization finished.
   logic suspend = 1'b0; // Suspend level.
   logic [3:0] on_req = 4'h0; // Power on pulses.
   logic [3:0] off_req = 4'h0; // Power off pulses.
   logic [3:0] port_en = 4'h5; // Port enable levels; ports 0 and 2 enabled.
   logic [3:0] clr_oc = 4'h0; // Change clear pulses.
   logic [3:0] overload = 4'h0; // Overload per port.
   logic hub_change = 1'b0; // Hub change level.
   logic [1:0] desc_sel = 2'h0; // Descriptor selector.
   logic [4:0] desc_idx = 5'h00; // Descriptor byte index.
   logic [3:0] oe, out_lvl, stat, oc, coc, pin_n, sense;
   logic [7:0] status_change, desc_byte, desc_len;
   logic osc_run;
   int n_mismatch = 0; // Mismatches seen.
   int samples_checked = 0; // Comparisons made.
   int cycles = 0; // Clock cycles for the hang guard.

   // Clock at 25 MHz.
   initial
   begin
      forever #20 clk = ~clk;
   end

   hppd_top #(.N_PORTS(4), .FAULT_CNT(FCNT), .VENDOR_ID(VID), .PRODUCT_ID(PID),
      .DEV_RELEASE(REL)) u_dut (.i_clk_sys(clk), .i_srst(srst), .i_init_done(init_done),
      .i_suspend(suspend), .i_port_power_on_request(on_req),
      .i_port_power_off_request(off_req), .i_port_enable(port_en),
      .i_port_supply_sense(sense), .i_clr_oc_change(clr_oc), .i_hub_change(hub_change),
      .i_desc_sel(desc_sel), .i_desc_idx(desc_idx), .o_port_power_ctl_n_oe(oe),
      .o_port_power_ctl_n_out(out_lvl), .o_port_stat(stat), .o_port_over_current(oc),
      .o_c_port_over_current(coc), .o_status_change(status_change), .o_osc_run(osc_run),
      .o_desc_byte(desc_byte), .o_desc_len(desc_len));

   hppd_port_model u_ports (.i_oe(oe), .i_out(out_lvl), .i_overload(overload),
      .o_pin_n(pin_n), .o_sense(sense));

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   // Compares a four-bit per-port vector.
   task automatic chk_port(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_port

   // Compares a byte-wide result.
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte

   // Issues a one-cycle power request; returns once its effect has landed.
   task automatic pulse_req(input logic on, input logic [3:0] m);
      if (on)
         on_req = m;
      else
         off_req = m;
      @(negedge clk);
      // Only the line that was raised drops, so a following call never
      // writes the same signal twice in one time step.
      if (on)
         on_req = 4'h0;
      else
         off_req = 4'h0;
   endtask : pulse_req

   // Expected descriptor byte; anything past the end reads zero.
   function automatic logic [7:0] exp_desc(input int s, input int i);
      if (s == 0 && i < 18)
         return DEV[i];
      if (s == 1 && i < 9)
         return CFG[i];
      if (s == 2 && i < 9)
         return IFC[i];
      return 8'h00;
   endfunction : exp_desc

   // Hang guard: far above the few hundred cycles the tests need.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   // Main sequence; every input changes on the falling edge.
   initial
   begin
      repeat (20) @(negedge clk);
      srst = 1'b0;
      chk_port(oe, 4'h0);
      chk_port(stat, 4'h0);
      chk_byte({7'h00, osc_run}, 8'h01);
      // Requests before initialization ends must be ignored.
      pulse_req(1'b1, 4'hF);
      chk_port(pin_n, 4'hF);
      init_done = 1'b1;
      @(negedge clk);
      pulse_req(1'b1, 4'h3);
      chk_port(oe, 4'h3);
      chk_port(pin_n, 4'hC);
      chk_port(stat, 4'h1);
      $display("Test power_on finished");
      // A dip one sample short of the limit must be ignored and restart the count.
      overload = 4'h1;
      repeat (FCNT) @(negedge clk);
      overload = 4'h0;
      @(negedge clk);
      chk_port(oe, 4'h3);
      overload = 4'h1;
      repeat (FCNT) @(negedge clk);
      chk_port(oc, 4'h0);
      @(negedge clk);
      chk_port(oe, 4'h2);
      chk_port(oc, 4'h1);
      chk_port(coc, 4'h1);
      hub_change = 1'b1;
      @(negedge clk);
      chk_byte(status_change, 8'h03);
      overload = 4'h0;
      hub_change = 1'b0;
      clr_oc = 4'h1;
      @(negedge clk);
      clr_oc = 4'h0;
      chk_port(coc, 4'h0);
      @(negedge clk);
      chk_byte(status_change, 8'h00);
      $display("Test overload finished");
      pulse_req(1'b1, 4'h1);
      chk_port(oc, 4'h0);
      pulse_req(1'b0, 4'h2);
      chk_port(pin_n, 4'hE);
      suspend = 1'b1;
      @(negedge clk);
      chk_byte({7'h00, osc_run}, 8'h00);
      suspend = 1'b0;
      @(negedge clk);
      chk_byte({7'h00, osc_run}, 8'h01);
      srst = 1'b1;
      @(negedge clk);
      srst = 1'b0;
      chk_port(oe, 4'h0);
      $display("Test suspend_reset finished");
      // Walk every selector over every index, including past the end.
      for (int s = 0; s < 4; s++)
      begin
         for (int i = 0; i < 32; i++)
         begin
            desc_sel = s[1:0];
            desc_idx = i[4:0];
            @(negedge clk);
            chk_byte(desc_byte, exp_desc(s, i));
            if (s < 3)
               chk_byte(desc_len, (s == 0) ? 8'h12 : 8'h09);
         end
      end
      $display("Test descriptors finished");
      give_verdict();
   end
endmodule : tb_top
